// file: rtl/ast_cfg.svh
`ifndef AST_CFG_SVH
`define AST_CFG_SVH

// Register byte offsets
`define AST_OFF_TXCTL     8'h00
`define AST_OFF_PORT      8'h04
`define AST_OFF_BAUD      8'h08
`define AST_OFF_DATA      8'h0C

// Transmit control and status fields
`define AST_TXCTL_TRANSMIT_ENABLE_BIT    0
`define AST_TXCTL_NINE    1
`define AST_TXCTL_BIT8    2
`define AST_TXCTL_SYNC    3
`define AST_TXCTL_EMPTY   4
`define AST_TXCTL_READY   5

// Port control fields
`define AST_PORT_PORT_MASTER_ENABLE     0
`define AST_PORT_OUT_DIR  1
`define AST_PORT_OUT_LAT  2
`define AST_PORT_IN_DIR   3
`define AST_PORT_IN_LAT   4
`define AST_PORT_OUT_LVL  5
`define AST_PORT_IN_LVL   6

// Reset values
`define AST_RST_BAUD      8'h00
`define AST_RST_DIR       1'b1

// Timing: bit period is PRESCALE * (divisor + 1) clocks
`define AST_PRESCALE      13'h0010
`define AST_FRAME_BITS8   4'hA
`define AST_FRAME_BITS9   4'hB

`endif

// file: rtl/ast_pkg.sv
package ast_pkg;

  typedef enum logic [1:0] {
    AST_IDLE  = 2'b01,
    AST_SHIFT = 2'b10
  } ast_state_t;

endpackage : ast_pkg

// file: rtl/ast_tx.sv
`timescale 1ns/100ps
`default_nettype none
`include "ast_cfg.svh"

// Notes on behaviour
// - Idle line sits at mark level
// - Start space, 8/9 data, stop mark
// - Every bit lasts one bit period
// - Bit period from 8-bit divisor
// - Data bits leave LSB first
// - One format and rate shared
// - No hardware parity; ninth bit free
// - Enables start transmitter, drive output pin
// - Port enable forces input pin input
// - Enabling transmitter sets ready flag
// - Write starts send, moves when free
// - Pending char moves after stop bit
// - Frame starts right after move
// - Shifter hidden; fed only from buffer
// - Ready clear when busy plus pending, or when disabled or in clocked mode
// - Ready valid right after the write edge
// - Empty flag tracks shifter occupancy
// - Nine-bit mode sends ninth as MSB
module ast_tx (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial output pin
  input  wire logic        serial_out_pin_in,
  output logic             serial_out_pin_out,
  output logic             serial_out_pin_oe,
  // Serial input pin
  input  wire logic        serial_in_pin_in,
  output logic             serial_in_pin_out,
  output logic             serial_in_pin_oe,
  // Status
  output logic             tx_ready_flag,
  output logic             shifter_empty_flag
);
  import ast_pkg::*;

  // Last clock count of one bit period
  function automatic logic [12:0] last_count(input logic [7:0] div);
    last_count = 13'(`AST_PRESCALE * ({5'h00, div} + 13'h0001)) - 13'h0001;
  endfunction : last_count

  // start at bit 0, data LSB first, stop on top
  function automatic logic [10:0] frame_of(input logic nine, input logic [8:0] ch);
    if (nine) begin
      frame_of = {1'b1, ch, 1'b0};
    end else begin
      frame_of = {2'b11, ch[7:0], 1'b0};
    end
  endfunction : frame_of

  // Bits left to send, stop bit included
  function automatic logic [3:0] frame_len_of(input logic nine);
    frame_len_of = nine ? `AST_FRAME_BITS9 : `AST_FRAME_BITS8;
  endfunction : frame_len_of

  // Shifter holds a frame in this state
  function automatic logic is_busy(input ast_state_t st);
    is_busy = (st == AST_SHIFT);
  endfunction : is_busy

  // Control registers
  logic        transmit_enable_bit_reg;
  logic        nine_bit_tx_select_reg;
  logic        ninth_tx_bit_reg;
  logic        clocked_mode_reg;
  logic        port_master_enable_reg;
  logic        out_dir_reg;
  logic        out_lat_reg;
  logic        in_dir_reg;
  logic        in_lat_reg;
  logic [7:0]  baud_div_reg;
  // Transmit datapath
  logic [8:0]  holding_buffer_reg;
  logic        hold_full_reg;
  logic [10:0] transmit_shifter_reg;
  logic [10:0] shifter_next;
  logic [3:0]  bits_left_reg;
  logic [3:0]  bits_left_next;
  logic [12:0] bit_cnt_reg;
  logic [12:0] bit_cnt_next;
  ast_state_t  state_reg;
  ast_state_t  state_next;
  logic        hold_full_next;
  logic        line_next;
  // Pin synchronisers
  logic        in_meta_reg;
  logic        in_sync_reg;
  logic        outpin_meta_reg;
  logic        outpin_sync_reg;
  // Bus outputs and status
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        ser_out_reg;
  logic        ser_out_oe_reg;
  logic        ser_in_out_reg;
  logic        ser_in_oe_reg;
  logic        ready_reg;
  logic        empty_reg;

  // APB decode
  wire         apb_access = psel & penable;
  wire         apb_first  = apb_access & ~pready_reg;
  // Writes land at the edge that ends the access
  wire         apb_done   = apb_access & pready_reg;
  wire         wr_en      = apb_done & pwrite;
  wire         hit_txctl  = (paddr == `AST_OFF_TXCTL);
  wire         hit_port   = (paddr == `AST_OFF_PORT);
  wire         hit_baud   = (paddr == `AST_OFF_BAUD);
  wire         hit_data   = (paddr == `AST_OFF_DATA);
  wire         bad_addr   = ~(hit_txctl | hit_port | hit_baud | hit_data);

  logic [31:0] txctl_rd;
  logic [31:0] port_rd;
  always_comb begin
    txctl_rd = 32'h0000_0000;
    txctl_rd[`AST_TXCTL_TRANSMIT_ENABLE_BIT]  = transmit_enable_bit_reg;
    txctl_rd[`AST_TXCTL_NINE]  = nine_bit_tx_select_reg;
    txctl_rd[`AST_TXCTL_BIT8]  = ninth_tx_bit_reg;
    txctl_rd[`AST_TXCTL_SYNC]  = clocked_mode_reg;
    txctl_rd[`AST_TXCTL_EMPTY] = empty_reg;
    txctl_rd[`AST_TXCTL_READY] = ready_reg;
    port_rd = 32'h0000_0000;
    port_rd[`AST_PORT_PORT_MASTER_ENABLE]    = port_master_enable_reg;
    port_rd[`AST_PORT_OUT_DIR] = out_dir_reg;
    port_rd[`AST_PORT_OUT_LAT] = out_lat_reg;
    port_rd[`AST_PORT_IN_DIR]  = in_dir_reg;
    port_rd[`AST_PORT_IN_LAT]  = in_lat_reg;
    port_rd[`AST_PORT_OUT_LVL] = outpin_sync_reg;
    port_rd[`AST_PORT_IN_LVL]  = in_sync_reg;
  end

  // shifter itself never on the bus
  wire [31:0] rd_mux = hit_txctl ? txctl_rd :
                       hit_port  ? port_rd :
                       hit_baud  ? {24'h000000, baud_div_reg} :
                       hit_data  ? {23'h000000, holding_buffer_reg} :
                       32'h0000_0000;

  // One wait state: pready stands in the second access cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first & bad_addr;
      prdata_reg  <= (apb_first & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Transmit control writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      transmit_enable_bit_reg <= 1'b0;
      nine_bit_tx_select_reg  <= 1'b0;
      ninth_tx_bit_reg        <= 1'b0;
      clocked_mode_reg        <= 1'b0;
    end else if (wr_en & hit_txctl) begin
      transmit_enable_bit_reg <= pwdata[`AST_TXCTL_TRANSMIT_ENABLE_BIT];
      nine_bit_tx_select_reg  <= pwdata[`AST_TXCTL_NINE];
      ninth_tx_bit_reg        <= pwdata[`AST_TXCTL_BIT8];
      clocked_mode_reg        <= pwdata[`AST_TXCTL_SYNC];
    end
  end

  // Port control writes; pins return to input on reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_master_enable_reg <= 1'b0;
      out_dir_reg            <= `AST_RST_DIR;
      out_lat_reg            <= 1'b0;
      in_dir_reg             <= `AST_RST_DIR;
      in_lat_reg             <= 1'b0;
    end else if (wr_en & hit_port) begin
      port_master_enable_reg <= pwdata[`AST_PORT_PORT_MASTER_ENABLE];
      out_dir_reg            <= pwdata[`AST_PORT_OUT_DIR];
      out_lat_reg            <= pwdata[`AST_PORT_OUT_LAT];
      in_dir_reg             <= pwdata[`AST_PORT_IN_DIR];
      in_lat_reg             <= pwdata[`AST_PORT_IN_LAT];
    end
  end

  // change only while idle: a value whose last count lies below the count already reached mid-bit stretches that bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baud_div_reg <= `AST_RST_BAUD;
    end else if (wr_en & hit_baud) begin
      baud_div_reg <= pwdata[7:0];
    end
  end

  // Transmitter timing
  // Clearing the enable or picking clocked mode drops the frame at once;
  // a character already waiting in the buffer is kept for later
  wire        tx_run    = transmit_enable_bit_reg & ~clocked_mode_reg;
  wire        shifting  = is_busy(state_reg);
  wire        bit_end   = shifting & (bit_cnt_reg == last_count(baud_div_reg));
  // Last clock of the stop bit
  wire        last_bit  = bit_end & (bits_left_reg == 4'h1);
  wire        hold_wr   = wr_en & hit_data;
  // move when idle or stop done
  wire        load      = tx_run & hold_full_reg & (~shifting | last_bit);
  // one format bit and one divisor serve every frame
  wire [10:0] frame     = frame_of(nine_bit_tx_select_reg, holding_buffer_reg);
  wire [3:0]  frame_len = frame_len_of(nine_bit_tx_select_reg);

  always_comb begin
    state_next     = state_reg;
    shifter_next   = transmit_shifter_reg;
    bits_left_next = bits_left_reg;
    // Count clocks within the current bit
    bit_cnt_next   = shifting ? bit_cnt_reg + 13'h0001 : 13'h0000;
    if (!tx_run) begin
      state_next     = AST_IDLE;
      shifter_next   = 11'h7FF;
      bits_left_next = 4'h0;
      bit_cnt_next   = 13'h0000;
    end else if (load) begin
      state_next     = AST_SHIFT;
      shifter_next   = frame;
      bits_left_next = frame_len;
      bit_cnt_next   = 13'h0000;
    end else if (last_bit) begin
      state_next     = AST_IDLE;
      shifter_next   = 11'h7FF;
      bits_left_next = 4'h0;
    end else if (bit_end) begin
      shifter_next   = {1'b1, transmit_shifter_reg[10:1]};
      bits_left_next = bits_left_reg - 4'h1;
      bit_cnt_next   = 13'h0000;
    end
    // A write in the load cycle queues the new character
    // A write while one already waits replaces it
    hold_full_next = hold_wr | (hold_full_reg & ~load);
    line_next      = is_busy(state_next) ? shifter_next[0] : 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg            <= AST_IDLE;
      transmit_shifter_reg <= 11'h7FF;
      bits_left_reg        <= 4'h0;
      bit_cnt_reg          <= 13'h0000;
      hold_full_reg        <= 1'b0;
      holding_buffer_reg   <= 9'h000;
    end else begin
      state_reg            <= state_next;
      transmit_shifter_reg <= shifter_next;
      bits_left_reg        <= bits_left_next;
      bit_cnt_reg          <= bit_cnt_next;
      hold_full_reg        <= hold_full_next;
      if (hold_wr) begin
        // ninth bit taken from control at write
        holding_buffer_reg <= {ninth_tx_bit_reg, pwdata[7:0]};
      end
    end
  end

  // Status flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      ready_reg <= tx_run & ~(is_busy(state_next) & hold_full_next);
      // empty while no frame in shifter
      empty_reg <= ~is_busy(state_next);
    end
  end

  // Pin drivers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ser_out_reg    <= 1'b1;
      ser_out_oe_reg <= 1'b0;
      ser_in_out_reg <= 1'b0;
      ser_in_oe_reg  <= 1'b0;
    end else begin
      // port enable makes output pin drive
      ser_out_reg    <= port_master_enable_reg ? line_next : out_lat_reg;
      ser_out_oe_reg <= port_master_enable_reg | ~out_dir_reg;
      // input pin forced input, latch blocked
      ser_in_out_reg <= port_master_enable_reg ? 1'b0 : in_lat_reg;
      ser_in_oe_reg  <= ~port_master_enable_reg & ~in_dir_reg;
    end
  end

  // Pin levels pass two flops before the read mux sees them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_meta_reg     <= 1'b1;
      in_sync_reg     <= 1'b1;
      outpin_meta_reg <= 1'b1;
      outpin_sync_reg <= 1'b1;
    end else begin
      in_meta_reg     <= serial_in_pin_in;
      in_sync_reg     <= in_meta_reg;
      outpin_meta_reg <= serial_out_pin_in;
      outpin_sync_reg <= outpin_meta_reg;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign serial_out_pin_out = ser_out_reg;
  assign serial_out_pin_oe  = ser_out_oe_reg;
  assign serial_in_pin_out  = ser_in_out_reg;
  assign serial_in_pin_oe   = ser_in_oe_reg;
  assign tx_ready_flag      = ready_reg;
  assign shifter_empty_flag = empty_reg;

endmodule : ast_tx

`default_nettype wire

// file: sim/ast_tx_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ast_tx_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Line and status
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe,
  input wire logic tx_ready_flag,
  input wire logic shifter_empty_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_move; $fell(shifter_empty_flag); endsequence
  AST_PREADY_WAIT: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready missing after one wait state");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_START_SPACE: assert property (s_move |-> (!serial_out_pin_out)[*8])
    else $error("start bit not at space");
  AST_READY_ON_MOVE: assert property (s_move |-> tx_ready_flag)
    else $error("ready flag low after move");
  AST_STOP_MARK: assert property ($rose(shifter_empty_flag) |-> serial_out_pin_out)
    else $error("line not at mark after frame");
  AST_IDLE_MARK: assert property (shifter_empty_flag && serial_out_pin_oe |-> serial_out_pin_out)
    else $error("idle line not at mark");
  AST_BIT_HOLD: assert property (!shifter_empty_flag && $changed(serial_out_pin_out)
    |=> $stable(serial_out_pin_out)[*8])
    else $error("bit shorter than one period");
endmodule : ast_tx_asserts
`default_nettype wire

// file: sim/ast_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module ast_rx_model (
  // Clock and line
  input  wire logic        sys_clk,
  input  wire logic        line,
  // Format
  input  wire logic        nine,
  input  wire logic [12:0] bit_clks,
  // Received characters
  output logic      [8:0]  rx_char,
  output logic      [7:0]  rx_count,
  output logic      [7:0]  ferr_count
);
  logic [8:0] sh;
  initial begin
    rx_char    = 9'h000;
    rx_count   = 8'h00;
    ferr_count = 8'h00;
    forever begin
      @(posedge sys_clk iff !line);
      sh = 9'h000;
      repeat (bit_clks / 2) @(posedge sys_clk);
      if (line) ferr_count++;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_clks) @(posedge sys_clk);
        sh[i] = line;
      end
      repeat (bit_clks) @(posedge sys_clk);
      if (!line) ferr_count++;
      rx_char = sh;
      rx_count++;
    end
  end
endmodule : ast_rx_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ast_cfg.svh"
module tb;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, in_lvl, nine;
  logic        serial_out_pin_out, serial_out_pin_oe, serial_in_pin_oe, in_out;
  logic        tx_ready_flag, shifter_empty_flag, err;
  logic [7:0]  paddr, rx_count, ferr_count;
  logic [8:0]  rx_char;
  logic [12:0] bit_clks;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, compares;
  // Pulled-up line seen by the pin and the receiver
  wire logic   line = serial_out_pin_oe ? serial_out_pin_out : 1'b1;
  wire logic [3:0] pins = {serial_out_pin_out, serial_out_pin_oe, in_out, serial_in_pin_oe};
  always #4 sys_clk = ~sys_clk;
  ast_tx ast_tx_inst (.sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .serial_out_pin_in(line), .serial_out_pin_out, .serial_out_pin_oe,
    .serial_in_pin_in(in_lvl), .serial_in_pin_out(in_out), .serial_in_pin_oe, .tx_ready_flag,
    .shifter_empty_flag);
  ast_rx_model ast_rx_model_inst (.sys_clk, .line, .nine, .bit_clks, .rx_char, .rx_count,
    .ferr_count);
  task automatic test_done;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Look at the answer mid-cycle, where it has settled
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    // Release only after the edge that samples pready high
    @(posedge sys_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 20) begin n_errors++; test_done(); end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk("rdata", exp, rd);
  endtask : rdc
  task automatic rx_wait(input logic [7:0] cnt, input logic [8:0] exp);
    int n;
    for (n = 0; n < 2000 && rx_count !== cnt; n++) @(posedge sys_clk);
    if (n >= 2000) begin n_errors++; test_done(); end
    chk("rx_char", {23'h0, exp}, {23'h0, rx_char});
  endtask : rx_wait
  initial begin
    sys_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; in_lvl = 1; nine = 0; bit_clks = 13'h0010; n_errors = 0; compares = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdc(`AST_OFF_TXCTL, 32'h10);
    rdc(`AST_OFF_PORT, 32'h6A);
    rdc(`AST_OFF_BAUD, 32'h00);
    chk("pslverr", 32'h0, {31'h0, err});
    rdc(8'h10, 32'h00);
    chk("pslverr", 32'h1, {31'h0, err});
    in_lvl <= 1'b0;
    apb(`AST_OFF_PORT, 1'b1, 32'h14);
    rdc(`AST_OFF_PORT, 32'h34);
    chk("pins", 32'hF, {28'h0, pins});
    // port enable, then transmitter on in async mode
    apb(`AST_OFF_PORT, 1'b1, 32'h11);
    apb(`AST_OFF_TXCTL, 1'b1, 32'h01);
    rdc(`AST_OFF_TXCTL, 32'h31);
    chk("pins", 32'hC, {28'h0, pins});
    apb(`AST_OFF_DATA, 1'b1, 32'hA5);
    apb(`AST_OFF_DATA, 1'b1, 32'h3C);
    rdc(`AST_OFF_TXCTL, 32'h01);
    rx_wait(8'h01, 9'h0A5);
    rx_wait(8'h02, 9'h03C);
    // ninth bit written before the low byte
    apb(`AST_OFF_TXCTL, 1'b1, 32'h07);
    nine <= 1'b1;
    apb(`AST_OFF_DATA, 1'b1, 32'h55);
    rx_wait(8'h03, 9'h155);
    repeat (40) @(posedge sys_clk);
    apb(`AST_OFF_TXCTL, 1'b1, 32'h01);
    nine <= 1'b0;
    apb(`AST_OFF_BAUD, 1'b1, 32'h02);
    bit_clks <= 13'h0030;
    apb(`AST_OFF_DATA, 1'b1, 32'h81);
    rx_wait(8'h04, 9'h081);
    repeat (60) @(posedge sys_clk);
    rdc(`AST_OFF_TXCTL, 32'h31);
    rdc(`AST_OFF_DATA, 32'h081);
    apb(`AST_OFF_TXCTL, 1'b1, 32'h09);
    rdc(`AST_OFF_TXCTL, 32'h19);
    apb(`AST_OFF_TXCTL, 1'b1, 32'h00);
    rdc(`AST_OFF_TXCTL, 32'h10);
    chk("ferr", 32'h0, {24'h0, ferr_count});
    test_done();
  end
endmodule : tb
bind ast_tx ast_tx_asserts ast_tx_asserts_inst (.sys_clk, .rst, .psel, .penable, .pready,
  .pslverr, .serial_out_pin_out, .serial_out_pin_oe, .tx_ready_flag, .shifter_empty_flag);
`default_nettype wire
